// [shared/pin_state_cfg.svh]
// reset and instruction register constants for the management and test pin state control
`ifndef PIN_STATE_CFG_SVH
`define PIN_STATE_CFG_SVH
// synchroniser reset holds power down pins, data in and test reset high, mode select low, test clock high
`define SYNC_RESET_VAL   6'h3B
`define TCK_RESET_VAL    1'b0
`define IR_WIDTH         4
`define IR_CAPTURE_VAL   4'h1
`define IR_BYPASS_VAL    4'hF
`endif

// [shared/pin_state_pkg.sv]
// types for the management and test pin state control
package pin_state_pkg;
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
      TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
      TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } tap_state_type;

   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_type;

   typedef struct packed {
      logic tdi_pull_en;
      logic tms_pull_en;
      logic trst_pull_en;
   } pull_ctrl_type;
endpackage : pin_state_pkg

// [verilog/mgmt_test_pin_state_control.sv]
// pin drivers, pulls and test-port controller across reset and power down
//=============================================================
// Notes on behaviour
// RULE1: chip reset floats management and test outputs
// RULE2: register power down keeps management interface alive
// RULE3: host ignores some status during power down
// RULE4: both power down pins low float both outputs
// RULE5: register power down drives management, floats test
// RULE6: test output floats unless shifting out
// RULE7: test reset low forces functional mode; pulldown
// RULE8: tester holds test reset high while testing
// RULE9: mode select steers controller; shifts on clock
// RULE10: pin power down disables pulls, register keeps
`timescale 1ns/1ns
`default_nettype none
`include "pin_state_cfg.svh"
module mgmt_test_pin_state_control #(
   parameter int IR_WIDTH = `IR_WIDTH
) (
   input  wire logic                        clk,
   input  wire logic                        rstn,
   input  wire logic                        chan_a_powerdown_pin_low,
   input  wire logic                        chan_b_powerdown_pin_low,
   input  wire logic                        chan_a_reg_powerdown,
   input  wire logic                        chan_b_reg_powerdown,
   input  wire logic                        mgmt_core_out,
   input  wire logic                        mgmt_core_oe,
   output var  pin_state_pkg::pin_drive_type mgmt_pin,
   output var  pin_state_pkg::pin_drive_type test_out_pin,
   output var  pin_state_pkg::pull_ctrl_type pulls,
   output logic                             mgmt_if_active,
   output logic                             scan_active,
   input  wire logic                        test_clk,
   input  wire logic                        test_mode_sel,
   input  wire logic                        test_data_in,
   input  wire logic                        test_reset_low,
   input  wire logic                        bypass_chain_in
);
   //=============================================================
   // input synchronisers
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic [5:0] sync1_d;
   logic       tck_prev_q;
   logic       tck_prev_d;

   always_comb
   begin
      sync1_d = {chan_a_powerdown_pin_low, chan_b_powerdown_pin_low, test_clk,
                 test_mode_sel, test_data_in, test_reset_low};
      tck_prev_d = sync2_q[3];
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         // test clock bit resets high against tck_prev_q low: one false rising edge is seen after reset
         sync1_q    <= `SYNC_RESET_VAL;
         sync2_q    <= `SYNC_RESET_VAL;
         tck_prev_q <= `TCK_RESET_VAL;
      end
      else
      begin
         sync1_q    <= sync1_d;
         sync2_q    <= sync1_q;
         tck_prev_q <= tck_prev_d;
      end
   end

   logic pin_pd;
   logic reg_pd;
   logic tck_rise;
   logic tck_fall;
   logic tms_s;
   logic tdi_s;
   logic trst_low_s;

   assign pin_pd     = !sync2_q[5] && !sync2_q[4];
   assign reg_pd     = chan_a_reg_powerdown && chan_b_reg_powerdown;
   assign tck_rise   = sync2_q[3] && !tck_prev_q;
   assign tck_fall   = !sync2_q[3] && tck_prev_q;
   assign tms_s      = sync2_q[2];
   assign tdi_s      = sync2_q[1];
   assign trst_low_s = !sync2_q[0];

   //=============================================================
   // test-port controller
   pin_state_pkg::tap_state_type state_q;
   pin_state_pkg::tap_state_type state_d;
   logic [IR_WIDTH-1:0] ir_shift_q;
   logic [IR_WIDTH-1:0] ir_shift_d;
   logic [IR_WIDTH-1:0] ir_q;
   logic [IR_WIDTH-1:0] ir_d;
   logic                bypass_q;
   logic                bypass_d;
   logic                tdo_q;
   logic                tdo_d;
   logic                shifting_q;
   logic                shifting_d;

   always_comb
   begin
      state_d    = state_q;
      ir_shift_d = ir_shift_q;
      ir_d       = ir_q;
      bypass_d   = bypass_q;
      tdo_d      = tdo_q;
      shifting_d = shifting_q;
      if (trst_low_s || pin_pd) // see RULE7
      begin
         state_d    = pin_state_pkg::TAP_RESET;
         ir_d       = IR_WIDTH'(`IR_BYPASS_VAL);
         shifting_d = 1'b0;
      end
      else if (tck_rise) // see RULE9
      begin
         unique case (state_q)
            pin_state_pkg::TAP_RESET:    state_d = tms_s ? pin_state_pkg::TAP_RESET
                                                         : pin_state_pkg::TAP_IDLE;
            pin_state_pkg::TAP_IDLE:     state_d = tms_s ? pin_state_pkg::TAP_SEL_DR
                                                         : pin_state_pkg::TAP_IDLE;
            pin_state_pkg::TAP_SEL_DR:   state_d = tms_s ? pin_state_pkg::TAP_SEL_IR
                                                         : pin_state_pkg::TAP_CAP_DR;
            pin_state_pkg::TAP_CAP_DR:   state_d = tms_s ? pin_state_pkg::TAP_EXIT1_DR
                                                         : pin_state_pkg::TAP_SHIFT_DR;
            pin_state_pkg::TAP_SHIFT_DR: state_d = tms_s ? pin_state_pkg::TAP_EXIT1_DR
                                                         : pin_state_pkg::TAP_SHIFT_DR;
            pin_state_pkg::TAP_EXIT1_DR: state_d = tms_s ? pin_state_pkg::TAP_UPD_DR
                                                         : pin_state_pkg::TAP_PAUSE_DR;
            pin_state_pkg::TAP_PAUSE_DR: state_d = tms_s ? pin_state_pkg::TAP_EXIT2_DR
                                                         : pin_state_pkg::TAP_PAUSE_DR;
            pin_state_pkg::TAP_EXIT2_DR: state_d = tms_s ? pin_state_pkg::TAP_UPD_DR
                                                         : pin_state_pkg::TAP_SHIFT_DR;
            pin_state_pkg::TAP_UPD_DR:   state_d = tms_s ? pin_state_pkg::TAP_SEL_DR
                                                         : pin_state_pkg::TAP_IDLE;
            pin_state_pkg::TAP_SEL_IR:   state_d = tms_s ? pin_state_pkg::TAP_RESET
                                                         : pin_state_pkg::TAP_CAP_IR;
            pin_state_pkg::TAP_CAP_IR:   state_d = tms_s ? pin_state_pkg::TAP_EXIT1_IR
                                                         : pin_state_pkg::TAP_SHIFT_IR;
            pin_state_pkg::TAP_SHIFT_IR: state_d = tms_s ? pin_state_pkg::TAP_EXIT1_IR
                                                         : pin_state_pkg::TAP_SHIFT_IR;
            pin_state_pkg::TAP_EXIT1_IR: state_d = tms_s ? pin_state_pkg::TAP_UPD_IR
                                                         : pin_state_pkg::TAP_PAUSE_IR;
            pin_state_pkg::TAP_PAUSE_IR: state_d = tms_s ? pin_state_pkg::TAP_EXIT2_IR
                                                         : pin_state_pkg::TAP_PAUSE_IR;
            pin_state_pkg::TAP_EXIT2_IR: state_d = tms_s ? pin_state_pkg::TAP_UPD_IR
                                                         : pin_state_pkg::TAP_SHIFT_IR;
            pin_state_pkg::TAP_UPD_IR:   state_d = tms_s ? pin_state_pkg::TAP_SEL_DR
                                                         : pin_state_pkg::TAP_IDLE;
         endcase
         unique case (state_q)
            pin_state_pkg::TAP_RESET:    ir_d = IR_WIDTH'(`IR_BYPASS_VAL);
            pin_state_pkg::TAP_CAP_IR:   ir_shift_d = IR_WIDTH'(`IR_CAPTURE_VAL);
            pin_state_pkg::TAP_SHIFT_IR: ir_shift_d = {tdi_s, ir_shift_q[IR_WIDTH-1:1]};
            pin_state_pkg::TAP_UPD_IR:   ir_d = ir_shift_q;
            pin_state_pkg::TAP_CAP_DR:   bypass_d = 1'b0;
            pin_state_pkg::TAP_SHIFT_DR: bypass_d = tdi_s;
            default:                     bypass_d = bypass_q;
         endcase
      end
      else if (tck_fall)
      begin
         // output changes on the falling edge, as a scan chain expects
         shifting_d = (state_q == pin_state_pkg::TAP_SHIFT_DR)
                   || (state_q == pin_state_pkg::TAP_SHIFT_IR); // see RULE6
         tdo_d      = (state_q == pin_state_pkg::TAP_SHIFT_IR) ? ir_shift_q[0]
                    : ((ir_q == IR_WIDTH'(`IR_BYPASS_VAL)) ? bypass_q : bypass_chain_in);
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q    <= pin_state_pkg::TAP_RESET;
         ir_shift_q <= '0;
         ir_q       <= IR_WIDTH'(`IR_BYPASS_VAL);
         bypass_q   <= 1'b0;
         tdo_q      <= 1'b0;
         shifting_q <= 1'b0;
      end
      else
      begin
         state_q    <= state_d;
         ir_shift_q <= ir_shift_d;
         ir_q       <= ir_d;
         bypass_q   <= bypass_d;
         tdo_q      <= tdo_d;
         shifting_q <= shifting_d;
      end
   end

   //=============================================================
   // pin drivers and pulls
   // reset floats pins combinationally, so no clock is needed to release them
   always_comb
   begin
      mgmt_if_active  = rstn && !pin_pd; // see RULE2
      mgmt_pin.out    = mgmt_core_out;
      mgmt_pin.oe     = rstn && !pin_pd && mgmt_core_oe; // see RULE1 see RULE4 see RULE5
      test_out_pin.out = tdo_q;
      // test reset drops the output at once, not one clock after the controller
      test_out_pin.oe  = rstn && !pin_pd && !reg_pd && !trst_low_s // see RULE1 see RULE5 see RULE7
                      && shifting_q; // see RULE6
      scan_active     = !trst_low_s && !pin_pd;
      // register power down leaves pulls on; only pin power down drops them
      pulls.tdi_pull_en  = !pin_pd; // see RULE10
      pulls.tms_pull_en  = !pin_pd; // see RULE10
      pulls.trst_pull_en = !pin_pd; // see RULE10 see RULE7
   end
endmodule : mgmt_test_pin_state_control
`default_nettype wire

// [sim/pin_state_asserts.sv]
// checker for the management and test pin state control
`timescale 1ns/1ns
`default_nettype none
module pin_state_asserts (
   input wire logic                         clk,
   input wire logic                         rstn,
   input wire logic                         chan_a_powerdown_pin_low,
   input wire logic                         chan_b_powerdown_pin_low,
   input wire logic                         chan_a_reg_powerdown,
   input wire logic                         chan_b_reg_powerdown,
   input wire logic                         mgmt_core_oe,
   input wire pin_state_pkg::pin_drive_type mgmt_pin,
   input wire pin_state_pkg::pin_drive_type test_out_pin,
   input wire pin_state_pkg::pull_ctrl_type pulls,
   input wire logic                         mgmt_if_active,
   input wire logic                         scan_active,
   input wire logic                         test_clk,
   input wire logic                         test_reset_low
);
   wire logic pd = !chan_a_powerdown_pin_low && !chan_b_powerdown_pin_low;
   wire logic rp = chan_a_reg_powerdown && chan_b_reg_powerdown;
   default clocking cb @(posedge clk); endclocking
   //==========================================
   // pin states
   a_reset_float: assert property (!rstn |-> !mgmt_pin.oe && !test_out_pin.oe)
      else $error("output driven during reset");
   a_pd_float: assert property (disable iff (!rstn) pd[*3] |-> !mgmt_pin.oe && !test_out_pin.oe)
      else $error("output driven in pin power down");
   a_pulls_off: assert property (disable iff (!rstn) pd[*3] |-> pulls == 3'h0)
      else $error("pulls on in pin power down");
   a_pulls_on: assert property (disable iff (!rstn) (!pd)[*3] |-> pulls == 3'h7)
      else $error("pulls off outside pin power down");
   a_regpd_pins: assert property (disable iff (!rstn) (rp && !pd)[*3] |->
      !test_out_pin.oe && mgmt_pin.oe == mgmt_core_oe) else $error("wrong pins in reg power down");
   a_mgmt_alive: assert property (disable iff (!rstn) (rp && !pd)[*3] |-> mgmt_if_active)
      else $error("management stopped in reg power down");
   a_tdo_float: assert property (disable iff (!rstn) test_out_pin.oe |-> scan_active)
      else $error("test output driven while scan idle");
   a_trst_off: assert property (disable iff (!rstn) (!test_reset_low)[*3] |-> !scan_active &&
      !test_out_pin.oe) else $error("scan active under test reset");
   a_tdo_holds: assert property (disable iff (!rstn) test_clk[*4] |-> $stable(test_out_pin.out))
      else $error("test output moved without test clock fall");
   c_shift: cover property (test_out_pin.oe);
   c_pd_exit: cover property (pd ##1 !pd);
   c_regpd: cover property (rp && mgmt_pin.oe);
endmodule : pin_state_asserts
`default_nettype wire

// [sim/scan_tester.sv]
// tester model driving the boundary-scan pins
`timescale 1ns/1ns
`default_nettype none
module scan_tester (
   input  wire logic clk,
   output logic      test_clk,
   output logic      test_mode_sel,
   output logic      test_data_in,
   output logic      test_reset_low
);
   initial
   begin
      {test_clk, test_mode_sel, test_data_in, test_reset_low} = 4'h6;
   end
   // test reset is raised only around scan work, then settles for the synchroniser
   task automatic set_test_reset(input logic level);
      test_reset_low = level;
      repeat (4) @(negedge clk);
   endtask : set_test_reset
   // tck stands low between calls; one period is 8 system clocks
   task automatic tick(input logic tms_v, input logic tdi_v);
      test_mode_sel = tms_v;
      test_data_in = tdi_v;
      repeat (4) @(negedge clk);
      test_clk = 1'b1;
      repeat (4) @(negedge clk);
      test_clk = 1'b0;
   endtask : tick
endmodule : scan_tester
`default_nettype wire

// [sim/tb_mgmt_test_pin_state_control.sv]
// bench for the management and test pin state control
`timescale 1ns/1ns
`default_nettype none
module tb_mgmt_test_pin_state_control;
   logic clk, rstn, pa, pb, ra, rb, core_out, core_oe, chain, if_act, scan_act;
   logic tck, tms, tdi, trst_low;
   pin_state_pkg::pin_drive_type mgmt_pin, test_out_pin;
   pin_state_pkg::pull_ctrl_type pulls;
   int errors = 0;
   int check_count = 0;
   mgmt_test_pin_state_control dut (.clk(clk), .rstn(rstn), .chan_a_powerdown_pin_low(pa),
      .chan_b_powerdown_pin_low(pb), .chan_a_reg_powerdown(ra), .chan_b_reg_powerdown(rb),
      .mgmt_core_out(core_out), .mgmt_core_oe(core_oe), .mgmt_pin(mgmt_pin),
      .test_out_pin(test_out_pin), .pulls(pulls), .mgmt_if_active(if_act),
      .scan_active(scan_act), .test_clk(tck), .test_mode_sel(tms), .test_data_in(tdi),
      .test_reset_low(trst_low), .bypass_chain_in(chain));
   scan_tester tester (.clk(clk), .test_clk(tck), .test_mode_sel(tms), .test_data_in(tdi),
      .test_reset_low(trst_low));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   // tms bits are sent lsb first
   task automatic moves(input logic [7:0] bits, input int n);
      for (int i = 0; i < n; i++)
         tester.tick(bits[i], 1'b1);
      repeat (4) @(negedge clk);
   endtask : moves
   //==========================================
   // scenarios
   task automatic t_power();
      {pa, pb} = 2'b01;
      repeat (4) @(negedge clk);
      chk({mgmt_pin.oe, pulls}, 8'h0f);
      {pa, pb} = 2'b00;
      repeat (4) @(negedge clk);
      chk({mgmt_pin.oe, test_out_pin.oe, pulls}, 8'h00);
      {pa, pb, ra, rb} = 4'hf;
      repeat (4) @(negedge clk);
      chk({mgmt_pin.oe, test_out_pin.oe, if_act, pulls}, 8'h2f);
      core_out = 1'b0;
      @(negedge clk);
      chk(mgmt_pin.out, 1'b0);
      // status bits are left unjudged while powered down
      {ra, rb} = 2'b00;
      $display("power down test done");
   endtask : t_power
   task automatic t_scan();
      tester.set_test_reset(1'b1);
      moves(8'h1f, 6);
      moves(8'h03, 4);
      for (int i = 0; i < 4; i++)
      begin
         chk({test_out_pin.oe, test_out_pin.out}, {1'b1, i == 0});
         tester.tick(i == 3, 1'b1);
         repeat (4) @(negedge clk);
      end
      moves(8'h05, 5);
      chk({scan_act, test_out_pin.oe, test_out_pin.out}, 8'h06);
      for (int i = 0; i < 3; i++)
      begin
         tester.tick(1'b0, i[0]);
         repeat (4) @(negedge clk);
         chk(test_out_pin.out, i[0]);
      end
      tester.set_test_reset(1'b0);
      chk({scan_act, test_out_pin.oe}, 8'h00);
      $display("scan test done");
   endtask : t_scan
   task automatic t_chain();
      tester.set_test_reset(1'b1);
      moves(8'h1f, 6);
      moves(8'h03, 4);
      // an all-zero instruction selects the outside chain instead of bypass
      for (int i = 0; i < 4; i++)
         tester.tick(i == 3, 1'b0);
      moves(8'h05, 5);
      chain = 1'b1;
      tester.tick(1'b0, 1'b0);
      repeat (4) @(negedge clk);
      chk({test_out_pin.oe, test_out_pin.out}, 8'h03);
      chain = 1'b0;
      tester.tick(1'b0, 1'b0);
      repeat (4) @(negedge clk);
      chk({test_out_pin.oe, test_out_pin.out}, 8'h02);
      {ra, rb} = 2'b11;
      @(negedge clk);
      chk(test_out_pin.oe, 1'b0);
      {ra, rb} = 2'b00;
      @(negedge clk);
      chk(test_out_pin.oe, 1'b1);
      {pa, pb} = 2'b00;
      repeat (4) @(negedge clk);
      chk({test_out_pin.oe, mgmt_pin.oe, scan_act}, 8'h00);
      {pa, pb} = 2'b11;
      tester.set_test_reset(1'b0);
      $display("chain test done");
   endtask : t_chain
   initial
   begin
      {rstn, pa, pb, ra, rb, core_out, core_oe, chain} = 8'h66;
      repeat (3) @(negedge clk);
      chk({mgmt_pin.oe, test_out_pin.oe, pulls}, 8'h07);
      rstn = 1'b1;
      t_power();
      t_scan();
      t_chain();
      give_verdict();
   end
   initial
   begin
      #100000;
      errors++;
      give_verdict();
   end
endmodule : tb_mgmt_test_pin_state_control
bind mgmt_test_pin_state_control pin_state_asserts chk_i (
   .clk                      (clk),
   .rstn                     (rstn),
   .chan_a_powerdown_pin_low (chan_a_powerdown_pin_low),
   .chan_b_powerdown_pin_low (chan_b_powerdown_pin_low),
   .chan_a_reg_powerdown     (chan_a_reg_powerdown),
   .chan_b_reg_powerdown     (chan_b_reg_powerdown),
   .mgmt_core_oe             (mgmt_core_oe),
   .mgmt_pin                 (mgmt_pin),
   .test_out_pin             (test_out_pin),
   .pulls                    (pulls),
   .mgmt_if_active           (mgmt_if_active),
   .scan_active              (scan_active),
   .test_clk                 (test_clk),
   .test_reset_low           (test_reset_low)
);
`default_nettype wire
